/* File: pkg/nvm_pkg.sv */
// Package of constants and carriers for the non-volatile access block
package nvm_pkg;
   // Mode codes on the mode-select port
   localparam logic [7:0] MODE_PROG_CODE   = 8'h68;
   localparam logic [7:0] MODE_PROG_CONFIG = 8'h69;
   localparam logic [7:0] MODE_PROG_LOCK   = 8'h6b;
   localparam logic [7:0] MODE_PROG_KEY    = 8'h6c;
   localparam logic [7:0] MODE_VER_CODE    = 8'h28;
   localparam logic [7:0] MODE_VER_CONFIG  = 8'h29;
   localparam logic [7:0] MODE_VER_LOCK    = 8'h2b;
   // Address map
   localparam logic [15:0] CODE_LAST       = 16'h7fff;
   localparam logic [15:0] CONFIG_LOW_ADDR = 16'hfff8;
   localparam logic [15:0] CONFIG_HIGH_ADDR = 16'hfff9;
   localparam logic [15:0] LOCK_ZERO_ADDR  = 16'h0001;
   localparam logic [15:0] LOCK_ONE_ADDR   = 16'h0002;
   localparam logic [15:0] LOCK_TWO_ADDR   = 16'h0003;
   localparam logic [15:0] KEY_LAST        = 16'h007f;
   localparam logic [15:0] ID_ADDR_0       = 16'h0030;
   localparam logic [15:0] ID_ADDR_1       = 16'h0031;
   localparam logic [15:0] ID_ADDR_2       = 16'h0060;
   localparam logic [15:0] ID_ADDR_3       = 16'h0061;
   // Erased cell value
   localparam logic [7:0] ERASED_BYTE      = 8'hff;
   localparam logic [7:0] ZERO_BYTE        = 8'h00;
   // Lock level bit positions
   localparam int LOCK_L1 = 0;
   localparam int LOCK_L2 = 1;
   localparam int LOCK_L3 = 2;
   // Strobe sequencing
   localparam int SETUP_CYCLES = 2;

   // Programmer-side pins, already synchronised
   typedef struct packed {
      logic       code_strobe_n;
      logic       latch_program_strobe_n;
      logic       ext_access_vpp_pin;
      logic [7:0] mode_select_port;
      logic [7:0] address_high_port;
      logic [7:0] address_low_port;
      logic [7:0] data_in;
   } prog_pins_t;

   // Derived permissions
   typedef struct packed {
      logic prog_ok;
      logic verify_code_ok;
      logic ext_exec_ok;
      logic table_ext_ok;
   } perm_t;
endpackage

/* File: core/nvm_program_verify_security.sv */
// Parallel program and verify access to on-chip non-volatile memory
//
// Contract
// RULE_01 - Erased cells read one; programming only clears bits. Lock bits here erase to zero; programming sets them.
// RULE_02 - Programmer gives one 100 us pulse per byte under high voltage.
// RULE_03 - Lock 000 allows execution, verify, programming, external table reads.
// RULE_04 - Lock 001 refuses programming and external-code table reads.
// RULE_05 - Lock 01x also refuses verify of user code memory.
// RULE_06 - Lock 1xx also forbids external execution.
// RULE_07 - Higher levels always include all lower restrictions.
// RULE_08 - Verify returns scrambled code when keys are programmed.
// RULE_09 - Lock verify returns lock bits in three low bits.
// RULE_10 - Config and lock always verifiable; keys never returned.
// RULE_11 - Code verify XNORs byte with key chosen by address bits 6:0.
// RULE_12 - Erased key array leaves verified code unchanged.
// RULE_13 - Processor table reads return unscrambled contents.
// RULE_14 - Identification bytes at 30h,31h,60h,61h, read-only, signature mode.
// RULE_15 - Programmer holds reset asserted for the whole sequence; here reset must stay low, as reset holds the sequencer in ST_IDLE.
// RULE_16 - Programmer first drives strobes and mode port high.
// RULE_17 - Code strobe goes low after two or more high cycles.
// RULE_18 - Mode codes 68h,69h,6Bh,6Ch select program areas; held stable.
// RULE_19 - Address high and low bytes on two ports, data on third.
// RULE_20 - Valid addresses per area: code, config, lock, key ranges.
// RULE_21 - Program: raise high voltage, then one low program strobe pulse.
// RULE_22 - Voltage lowered before ending program; release signals to end.
// RULE_23 - Verify with strobe high; 28h code, 29h config/id, 2Bh lock.
// RULE_24 - Verify drives the addressed byte onto the data port.
// RULE_25 - Program pulse waveform timing is a programmer-side parameter.
`timescale 1ns/1ns
`default_nettype none
module nvm_program_verify_security
   import nvm_pkg::*;
#(
   parameter int        CODE_DEPTH = 32768,
   parameter int        KEY_DEPTH  = 128,
   parameter logic [7:0] ID_BYTE_0 = 8'h11, // Arbitrary value
   parameter logic [7:0] ID_BYTE_1 = 8'h22, // Arbitrary value
   parameter logic [7:0] ID_BYTE_2 = 8'h33, // Arbitrary value
   parameter logic [7:0] ID_BYTE_3 = 8'h44  // Arbitrary value
)
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       code_strobe_n,
   input  wire logic       latch_program_strobe_n,
   input  wire logic       ext_access_vpp_pin,
   input  wire logic [7:0] mode_select_port,
   input  wire logic [7:0] address_high_port,
   input  wire logic [7:0] address_low_port,
   input  wire logic [7:0] data_port_in,
   output logic      [7:0] data_port_out,
   output logic            data_port_oe,
   input  wire logic [15:0] table_addr,
   input  wire logic       table_from_ext,
   output logic      [7:0] table_data,
   output logic            table_refused,
   output logic      [2:0] lock_level_bits,
   output logic            ext_exec_allowed,
   output logic            prog_refused
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: two flops before any logic
   prog_pins_t meta;
   prog_pins_t pins;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         meta <= '1;
         pins <= '1;
      end
      else
      begin
         meta <= '{code_strobe_n, latch_program_strobe_n,
                   ext_access_vpp_pin, mode_select_port,
                   address_high_port, address_low_port, data_port_in};
         pins <= meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Entry sequence: reset released, all high, then code strobe low
   typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_ACTIVE} seq_t;
   seq_t       seq;
   logic [1:0] high_count;
   logic       all_high;
   assign all_high = pins.code_strobe_n && pins.latch_program_strobe_n
                     && (pins.mode_select_port == ERASED_BYTE);

   // Only a clean high-then-low strobe opens access; stray lows are ignored
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         seq        <= ST_IDLE;
         high_count <= 2'h0;
      end
      else
      begin
         case (seq)
            ST_IDLE:
            begin
               high_count <= 2'h0;
               if (all_high)
                  seq <= ST_HIGH; // RULE_16
            end
            ST_HIGH:
            begin
               if (!pins.code_strobe_n)
                  seq <= (high_count >= 2'(SETUP_CYCLES)) ? ST_ACTIVE
                                                          : ST_IDLE; // RULE_17
               else if (high_count < 2'(SETUP_CYCLES))
                  high_count <= high_count + 2'h1;
            end
            ST_ACTIVE:
               if (pins.code_strobe_n)
                  seq <= ST_IDLE; // RULE_22
            default:
               seq <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Non-volatile storage, bytes erased to ones, lock bits to zero; declared erased so the write
   // processes stay the only drivers and reset never touches the array
   logic [7:0] code_mem [CODE_DEPTH] = '{default: ERASED_BYTE};
   logic [7:0] key_mem  [KEY_DEPTH]  = '{default: ERASED_BYTE};
   logic [7:0] config_low  = ERASED_BYTE;
   logic [7:0] config_high = ERASED_BYTE;
   logic [2:0] lock_state  = '0;
   assign lock_level_bits = lock_state;
   logic [15:0] addr;
   logic [14:0] code_idx;
   logic [6:0]  key_idx;
   assign addr     = {pins.address_high_port, pins.address_low_port}; // RULE_19
   assign code_idx = addr[14:0];
   assign key_idx  = addr[6:0];

   ////////////////////////////////////////////////////////////////////////
   // Security levels, cumulative
   perm_t perm;
   logic  lvl1;
   logic  lvl2;
   logic  lvl3;
   assign lvl3 = lock_level_bits[LOCK_L3];
   assign lvl2 = lock_level_bits[LOCK_L2] | lvl3; // RULE_07
   assign lvl1 = lock_level_bits[LOCK_L1] | lvl2; // RULE_07
   assign perm.prog_ok        = !lvl1;            // RULE_03 RULE_04
   assign perm.table_ext_ok   = !lvl1;            // RULE_04
   assign perm.verify_code_ok = !lvl2;            // RULE_05
   assign perm.ext_exec_ok    = !lvl3;            // RULE_06
   assign ext_exec_allowed    = perm.ext_exec_ok;

   ////////////////////////////////////////////////////////////////////////
   // Program pulse detection: one write per falling strobe edge
   logic strobe_prev;
   logic prog_pulse;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         strobe_prev <= 1'b1;
      else
         strobe_prev <= pins.latch_program_strobe_n;
   end
   // High voltage must be up before the strobe falls
   assign prog_pulse = (seq == ST_ACTIVE) && strobe_prev
                       && !pins.latch_program_strobe_n
                       && pins.ext_access_vpp_pin; // RULE_21

   logic wr_code;
   logic wr_key;
   logic wr_cfg;
   logic wr_lock;
   logic area_prog;
   always_comb
   begin
      wr_code   = 1'b0;
      wr_key    = 1'b0;
      wr_cfg    = 1'b0;
      wr_lock   = 1'b0;
      area_prog = 1'b0;
      case (pins.mode_select_port) // RULE_18
         MODE_PROG_CODE:
         begin
            area_prog = 1'b1;
            wr_code   = (addr <= CODE_LAST); // RULE_20
         end
         MODE_PROG_CONFIG:
         begin
            area_prog = 1'b1;
            wr_cfg    = (addr == CONFIG_LOW_ADDR)
                        || (addr == CONFIG_HIGH_ADDR); // RULE_20
         end
         MODE_PROG_KEY:
         begin
            area_prog = 1'b1;
            wr_key    = (addr <= KEY_LAST); // RULE_20
         end
         MODE_PROG_LOCK:
            wr_lock = (addr >= LOCK_ZERO_ADDR)
                      && (addr <= LOCK_TWO_ADDR); // RULE_20
         default:
            area_prog = 1'b0;
      endcase
   end

   // Writes AND the data in: bits only fall from one to zero
   always_ff @(posedge ref_clk)
   begin
      if (prog_pulse && perm.prog_ok && wr_code)
         code_mem[code_idx] <= code_mem[code_idx] & pins.data_in; // RULE_01
      if (prog_pulse && perm.prog_ok && wr_key)
         key_mem[key_idx] <= key_mem[key_idx] & pins.data_in; // RULE_01
   end

   // Configuration bytes; factory state is erased
   always_ff @(posedge ref_clk)
   begin
      if (prog_pulse && perm.prog_ok && wr_cfg)
      begin
         if (addr == CONFIG_LOW_ADDR)
            config_low <= config_low & pins.data_in; // RULE_01
         else
            config_high <= config_high & pins.data_in;
      end
   end

   // Lock bits set on a pulse, data ignored; always allowed to raise level
   always_ff @(posedge ref_clk)
   begin
      if (prog_pulse && wr_lock)
      begin
         if (addr == LOCK_ZERO_ADDR)
            lock_state[LOCK_L1] <= 1'b1;
         else if (addr == LOCK_ONE_ADDR)
            lock_state[LOCK_L2] <= 1'b1;
         else
            lock_state[LOCK_L3] <= 1'b1;
      end
   end

   // Refused program attempt flag, held until next pulse
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         prog_refused <= 1'b0;
      else if (prog_pulse)
         prog_refused <= area_prog && !perm.prog_ok; // RULE_04
   end

   ////////////////////////////////////////////////////////////////////////
   // Verify read path
   logic [7:0] next_read;
   logic       next_oe;
   logic       verify_mode;
   assign verify_mode = (seq == ST_ACTIVE) && !pins.ext_access_vpp_pin
                        && pins.latch_program_strobe_n; // RULE_23
   always_comb
   begin
      next_read = ERASED_BYTE;
      next_oe   = verify_mode;
      case (pins.mode_select_port)
         MODE_VER_CODE:
            if (perm.verify_code_ok && addr <= CODE_LAST)
               next_read = ~(code_mem[code_idx]
                             ^ key_mem[key_idx]); // RULE_08 RULE_11 RULE_12
         MODE_VER_CONFIG:
            if (addr == CONFIG_LOW_ADDR)
               next_read = config_low; // RULE_10
            else if (addr == CONFIG_HIGH_ADDR)
               next_read = config_high;
            else if (addr == ID_ADDR_0)
               next_read = ID_BYTE_0; // RULE_14
            else if (addr == ID_ADDR_1)
               next_read = ID_BYTE_1;
            else if (addr == ID_ADDR_2)
               next_read = ID_BYTE_2;
            else if (addr == ID_ADDR_3)
               next_read = ID_BYTE_3;
         MODE_VER_LOCK:
            next_read = {5'h00, lock_level_bits}; // RULE_09 RULE_10
         default:
            next_oe = 1'b0; // Key array never readable
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         data_port_out <= ZERO_BYTE;
         data_port_oe  <= 1'b0;
      end
      else
      begin
         data_port_out <= next_read; // RULE_24
         data_port_oe  <= next_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Processor table reads: plain contents, gated only for external code
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         table_data    <= ZERO_BYTE;
         table_refused <= 1'b0;
      end
      else if (table_from_ext && !perm.table_ext_ok)
      begin
         table_data    <= ERASED_BYTE;
         table_refused <= 1'b1; // RULE_04
      end
      else
      begin
         table_data    <= code_mem[table_addr[14:0]]; // RULE_13
         table_refused <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence seq_lock_verify;
      verify_mode && pins.mode_select_port == MODE_VER_LOCK;
   endsequence

   AST_LOCK_READ: assert property (@(posedge ref_clk) disable iff (reset) // RULE_09
      seq_lock_verify |=> data_port_out[2:0] == $past(lock_level_bits))
      else $error("lock verify byte wrong");
   AST_CUMUL: assert property (@(posedge ref_clk) disable iff (reset) // RULE_07
      lock_level_bits[LOCK_L3] |-> !perm.prog_ok && !perm.verify_code_ok)
      else $error("level not cumulative");
   AST_EXT_EXEC: assert property (@(posedge ref_clk) disable iff (reset) // RULE_06
      ext_exec_allowed == !lock_level_bits[LOCK_L3])
      else $error("external execution gate wrong");
   AST_NO_KEY: assert property (@(posedge ref_clk) disable iff (reset) // RULE_10
      pins.mode_select_port == MODE_PROG_KEY |=> !data_port_oe)
      else $error("key array driven out");
   AST_CODE_HIDDEN: assert property (@(posedge ref_clk) disable iff (reset) // RULE_05
      verify_mode && lvl2 && pins.mode_select_port == MODE_VER_CODE
      |=> data_port_out == ERASED_BYTE)
      else $error("code visible at level two");
   AST_TABLE: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04
      table_from_ext && lvl1 |=> table_refused)
      else $error("external table read not refused");
   AST_PROG_REF: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04
      prog_pulse && area_prog && lvl1 |=> prog_refused)
      else $error("program not refused");
   AST_ENTRY: assert property (@(posedge ref_clk) disable iff (reset) // RULE_17
      $rose(seq == ST_ACTIVE) |-> $past(seq) == ST_HIGH
      && $past(high_count) >= 2'(SETUP_CYCLES))
      else $error("access opened without setup");
endmodule
`default_nettype wire

/* File: testbench/nvm_programmer_model.sv */
// Behavioural parallel programmer that drives the access pins
`timescale 1ns/1ns
`default_nettype none
module nvm_programmer_model
   import nvm_pkg::*;
#(
   parameter int PULSE_CYCLES  = 4, // Stands in for the long program pulse
   parameter int SETTLE_CYCLES = 4
)
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] data_port_out,
   input  wire logic       data_port_oe,
   output logic            code_strobe_n,
   output logic            latch_program_strobe_n,
   output logic            ext_access_vpp_pin,
   output logic      [7:0] mode_select_port,
   output logic      [7:0] address_high_port,
   output logic      [7:0] address_low_port,
   output logic      [7:0] data_port_in
);
   ////////////////////////////////////////////////////////////
   // Idle levels: all strobes and the mode port high
   initial
   begin
      code_strobe_n = 1'b1;
      latch_program_strobe_n = 1'b1;
      ext_access_vpp_pin = 1'b0;
      mode_select_port = 8'hff;
      address_high_port = 8'h00;
      address_low_port = 8'h00;
      data_port_in = 8'h00;
   end

   // Tasks run from a rising edge and leave at one
   task automatic open_access();
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
      code_strobe_n <= 1'b0;
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
   endtask

   // Exactly one pulse per byte, voltage up around it
   task automatic prog_byte(input logic [7:0] m, input logic [15:0] a,
                            input logic [7:0] d);
      mode_select_port <= m;
      {address_high_port, address_low_port} <= a;
      data_port_in <= d;
      ext_access_vpp_pin <= 1'b1;
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
      latch_program_strobe_n <= 1'b0;
      repeat (PULSE_CYCLES) @(posedge ref_clk);
      latch_program_strobe_n <= 1'b1;
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
      ext_access_vpp_pin <= 1'b0;
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
   endtask

   // Data port released: inverse shown so no stale byte passes
   task automatic verify(input logic [7:0] m, input logic [15:0] a,
                         output logic [7:0] d, output logic oe);
      mode_select_port <= m;
      {address_high_port, address_low_port} <= a;
      data_port_in <= ~data_port_in;
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
      @(negedge ref_clk);
      d = data_port_out;
      oe = data_port_oe;
      @(posedge ref_clk);
   endtask

   // Release the strobes to end the sequence
   task automatic close_access();
      code_strobe_n <= 1'b1;
      mode_select_port <= 8'hff;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

/* File: testbench/nvm_program_verify_security_tb.sv */
// Self-checking bench for program, verify and lock behaviour
`timescale 1ns/1ns
`default_nettype none
module nvm_program_verify_security_tb
   import nvm_pkg::*;
   ;
   localparam logic [15:0] ID_A [4] = '{ID_ADDR_0, ID_ADDR_1,
                                        ID_ADDR_2, ID_ADDR_3};
   localparam logic [7:0]  ID_V [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3}; // Arbitrary
   logic        ref_clk;
   logic        reset;
   logic [15:0] table_addr;
   logic        table_from_ext;
   wire  logic  code_strobe_n, latch_program_strobe_n, ext_access_vpp_pin;
   wire  logic [7:0] mode_select_port, address_high_port, address_low_port;
   wire  logic [7:0] data_port_in, data_port_out, table_data;
   wire  logic [2:0] lock_level_bits;
   wire  logic  data_port_oe, table_refused, ext_exec_allowed, prog_refused;
   logic [7:0]  code_m [logic [15:0]];
   logic [7:0]  key_m [128];
   logic [7:0]  cfg_m [2];
   logic [2:0]  lock_m;
   logic [15:0] a;
   logic [7:0]  d;
   int          i, cycles, fail_count, num_checks;
   int          lock_seq [4] = '{0, 2, 1, 3};

   ////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         stop_test();
      end
   end

   nvm_program_verify_security #(.ID_BYTE_0(ID_V[0]), .ID_BYTE_1(ID_V[1]),
      .ID_BYTE_2(ID_V[2]), .ID_BYTE_3(ID_V[3])) u_nvm_program_verify_security (
      .ref_clk(ref_clk), .reset(reset), .code_strobe_n(code_strobe_n),
      .latch_program_strobe_n(latch_program_strobe_n),
      .ext_access_vpp_pin(ext_access_vpp_pin),
      .mode_select_port(mode_select_port),
      .address_high_port(address_high_port),
      .address_low_port(address_low_port), .data_port_in(data_port_in),
      .data_port_out(data_port_out), .data_port_oe(data_port_oe),
      .table_addr(table_addr), .table_from_ext(table_from_ext),
      .table_data(table_data), .table_refused(table_refused),
      .lock_level_bits(lock_level_bits),
      .ext_exec_allowed(ext_exec_allowed), .prog_refused(prog_refused));

   nvm_programmer_model u_prog (
      .ref_clk(ref_clk), .data_port_out(data_port_out),
      .data_port_oe(data_port_oe), .code_strobe_n(code_strobe_n),
      .latch_program_strobe_n(latch_program_strobe_n),
      .ext_access_vpp_pin(ext_access_vpp_pin),
      .mode_select_port(mode_select_port),
      .address_high_port(address_high_port),
      .address_low_port(address_low_port), .data_port_in(data_port_in));

   ////////////////////////////////////////////////////////////
   // Reference model of the arrays and locks
   function automatic logic [7:0] code_at(input logic [15:0] x);
      return code_m.exists(x) ? code_m[x] : 8'hff;
   endfunction

   // Code verify: blanked from level 2, else scrambled
   function automatic logic [7:0] code_ver(input logic [15:0] x);
      if (lock_m[2:1] != 2'b00)
         return 8'hff;
      return ~(code_at(x) ^ key_m[x[6:0]]);
   endfunction

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Program one byte and mirror it; array bits only go one to zero, lock bits zero to one
   task automatic prog(input logic [7:0] m, input logic [15:0] x,
                       input logic [7:0] v);
      logic refuse;
      refuse = (lock_m != 3'b000) && (m != MODE_PROG_LOCK);
      u_prog.prog_byte(m, x, v);
      if (!refuse && m == MODE_PROG_CODE)
         code_m[x] = code_at(x) & v;
      if (!refuse && m == MODE_PROG_KEY)
         key_m[x[6:0]] &= v;
      if (!refuse && m == MODE_PROG_CONFIG)
         cfg_m[x[0]] &= v;
      if (m == MODE_PROG_LOCK)
         lock_m[x[1:0] - 2'd1] = 1'b1;
      chk_bit(prog_refused, refuse);
   endtask

   task automatic ver(input logic [7:0] m, input logic [15:0] x,
                      input logic exp_oe, output logic [7:0] v);
      logic oe;
      u_prog.verify(m, x, v, oe);
      chk_bit(oe, exp_oe);
   endtask

   // Processor table read, one edge to answer
   task automatic table_rd(input logic [15:0] x, input logic ext);
      logic refuse;
      refuse = ext && (lock_m != 3'b000);
      table_addr <= x;
      table_from_ext <= ext;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk_bit(table_refused, refuse);
      if (!refuse)
         chk_byte(table_data, code_at(x));
      @(posedge ref_clk);
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(32'h378d));
      reset = 1'b1;
      table_addr = 16'h0000;
      table_from_ext = 1'b0;
      lock_m = 3'b000;
      foreach (key_m[j]) key_m[j] = 8'hff;
      foreach (cfg_m[j]) cfg_m[j] = 8'hff;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      u_prog.open_access();
      a = 16'($urandom_range(32'h7fff));
      ver(MODE_VER_CODE, a, 1'b1, d);
      chk_byte(d, code_ver(a));
      // Keys and code at matching low address bits, key written once, code twice
      for (i = 0; i < 4; i++)
      begin
         a = 16'($urandom_range(32'h7fff));
         prog(MODE_PROG_KEY, {9'h000, a[6:0]}, 8'($urandom));
         prog(MODE_PROG_CODE, a, 8'($urandom));
         prog(MODE_PROG_CODE, a, 8'($urandom));
         ver(MODE_VER_CODE, a, 1'b1, d);
         chk_byte(d, code_ver(a));
         table_rd(a, i[0]);
      end
      prog(MODE_PROG_CONFIG, CONFIG_LOW_ADDR, 8'($urandom));
      prog(MODE_PROG_CONFIG, CONFIG_HIGH_ADDR, 8'($urandom));
      ver(8'h2c, 16'h0005, 1'b0, d);
      for (i = 0; i < 4; i++)
      begin
         ver(MODE_VER_CONFIG, ID_A[i], 1'b1, d);
         chk_byte(d, ID_V[i]);
      end
      // Walk the lock levels, lower bits sometimes still erased
      for (i = 0; i < 4; i++)
      begin
         if (lock_seq[i] != 0)
            prog(MODE_PROG_LOCK, 16'(lock_seq[i]), 8'($urandom));
         ver(MODE_VER_LOCK, 16'h0000, 1'b1, d);
         chk_byte({5'h00, d[2:0]}, {5'h00, lock_m});
         chk_byte({5'h00, lock_level_bits}, {5'h00, lock_m});
         chk_bit(ext_exec_allowed, !lock_m[2]);
         prog(MODE_PROG_CODE, a, 8'h00);
         prog(MODE_PROG_CONFIG, CONFIG_LOW_ADDR, 8'h00);
         ver(MODE_VER_CODE, a, 1'b1, d);
         chk_byte(d, code_ver(a));
         ver(MODE_VER_CONFIG, CONFIG_LOW_ADDR, 1'b1, d);
         chk_byte(d, cfg_m[0]);
         table_rd(a, 1'b1);
      end
      u_prog.close_access();
      stop_test();
   end
endmodule
`default_nettype wire
